//--- design/fca_top.sv
// feeder control, interlock and auto-reclose sequencer with apb registers
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module fca_top #(
  parameter int TICK_CYC = fca_pkg::TICK_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        reclose_start_a_i,
  input  wire logic        reclose_start_b_i,
  input  wire logic        reclose_start_c_i,
  input  wire logic        trip_i,
  input  wire logic [6:0]  obj_open_i,
  input  wire logic [6:0]  obj_closed_i,
  input  wire logic [6:0]  ext_in_i,
  input  wire logic [2:0]  int_in_i,
  input  wire logic        btn_step_i,
  input  wire logic        btn_select_i,
  input  wire logic        loc_open_i,
  input  wire logic        loc_close_i,
  input  wire logic [2:0]  loc_obj_i,
  output logic [5:0]       object_open_out_o,
  output logic [5:0]       object_close_out_o,
  output logic [1:0]       signal_out_o,
  output logic [15:0]      led_o,
  output logic [9:0]       bin_led_o,
  output logic             final_trip_o,
  output logic             ar_active_o
);

  if (TICK_CYC < 2 || TICK_CYC > 65535) begin : g_bad_tick
    $error("TICK_CYC out of range");
  end
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
  typedef struct packed {
    logic [fca_pkg::PIN_W-1:0] s1, s2, s3, pin;
    logic [15:0]               pre;
    logic [9:0]                ctrl, pol;
    logic [5:0]                len;
    logic [15:0]               sdly, recl;
    logic [4:0][15:0]          dead;
    logic [15:0]               pulse;
    logic [9:0]                ilkm, ilkv;
    logic [17:0]               doc;
    logic [15:0]               inact;
    logic [27:0]               ledm;
    logic [5:0][3:0]           lcnt;
    logic [5:0]                lat;
    logic [9:0]                bprev;
    logic [1:0]                lprev;
    logic                      tprev, sprev;
    logic [1:0]                cprev;
    logic                      lastc;
    logic [5:0]                p_open, p_close;
    logic [15:0]               ptmr;
    fca_pkg::fca_ar_e          st;
    logic [15:0]               art;
    logic [2:0]                shot;
    logic                      rdy, err;
    logic [31:0]               rdata;
    logic [5:0]                o_open, o_close;
    logic [1:0]                o_sig;
    logic [15:0]               led;
    logic [9:0]                bled;
    logic                      fin, act;
  } fca_state_s;
  fca_state_s q, n;
  logic [1:0] rst_q;
  logic       rst_n;

  // reset release through two flops
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // pick one binary channel, 10 and above means none
  function automatic logic fca_sel_ch(input logic [9:0] v, input logic [3:0] ch);
    fca_sel_ch = (ch < 4'ha) ? v[ch] : 1'b0;
  endfunction
  // decoded view of the filtered pins
  logic [2:0]  st_act, shots_eff, cmd_obj;
  logic [6:0]  obj_opn, obj_cls;
  logic [9:0]  bin_act, ilk_src;
  logic        tick, any_start, start_rise, trip_rise, use_dly, lat_clr, cmd_v, cmd_opn, permit, wr;
  logic [5:0]  new_open, new_close;
  logic [1:0]  brk_open, brk_close;
  assign st_act    = q.pin[fca_pkg::P_STA +: 3];
  assign obj_opn   = q.pin[fca_pkg::P_OPN +: 7];
  assign obj_cls   = q.pin[fca_pkg::P_CLS +: 7];
  assign bin_act   = {q.pin[fca_pkg::P_INT +: 3], q.pin[fca_pkg::P_EXT +: 7]} ^ q.pol;
  assign shots_eff = (q.ctrl[fca_pkg::C_SHOT +: 3] == 3'h0) ? 3'h1 :
                     (q.ctrl[fca_pkg::C_SHOT +: 3] > 3'(fca_pkg::N_SHOT)) ? 3'(fca_pkg::N_SHOT) :
                     q.ctrl[fca_pkg::C_SHOT +: 3];
  assign any_start = |st_act;
  assign start_rise = any_start & ~q.sprev;
  assign trip_rise = q.pin[fca_pkg::P_TRP] & ~q.tprev;
  assign use_dly   = ((st_act & ~q.ctrl[fca_pkg::C_SDLY +: 3]) == 3'h0) && (q.sdly != 16'h0);
  assign ilk_src   = q.ctrl[fca_pkg::C_ILK] ? bin_act : {3'h0, obj_cls};
  assign permit    = ((ilk_src ^ q.ilkv) & q.ilkm) == 10'h0;
  assign brk_open  = q.ctrl[fca_pkg::C_DUP] ? 2'h3 : 2'h1;
  assign brk_close = (q.ctrl[fca_pkg::C_DUP] && q.lastc) ? 2'h2 : 2'h1;
  assign wr        = psel_i & penable_i & q.rdy & pwrite_i & ~q.err;
  assign lat_clr   = (q.pin[fca_pkg::P_STEP] & q.pin[fca_pkg::P_SEL]) |
                     (wr && paddr_i == fca_pkg::A_LRST && pwdata_i < 32'h2);

  // whole next state
  always_comb begin
    logic [5:0] ar_open;
    logic [5:0] ar_close;
    logic [5:0] ok_m;
    ar_open  = 6'h0;
    ar_close = 6'h0;
    ok_m     = 6'h0;
    n = q;
    // three flop pin filter, second and third must agree
    n.s1  = {loc_obj_i, loc_close_i, loc_open_i, btn_select_i, btn_step_i, trip_i,
             int_in_i, ext_in_i, obj_closed_i, obj_open_i, reclose_start_c_i,
             reclose_start_b_i, reclose_start_a_i};
    n.s2  = q.s1;
    n.s3  = q.s2;
    n.pin = (q.s2 & q.s3) | (q.pin & (q.s2 | q.s3)); // hold while second and third disagree
    // millisecond tick
    tick  = (q.pre == TICK_LAST);
    n.pre = tick ? 16'h0 : q.pre + 16'h1;
    n.bprev = bin_act;
    n.lprev = {q.pin[fca_pkg::P_LCLS], q.pin[fca_pkg::P_LOPN]};
    n.tprev = q.pin[fca_pkg::P_TRP];
    n.sprev = any_start;
    n.cprev = obj_cls[1:0];
    // breaker closed most recently
    if (obj_cls[0] && !q.cprev[0]) begin
      n.lastc = 1'b0;
    end
    if (obj_cls[1] && !q.cprev[1]) begin
      n.lastc = 1'b1;
    end

    // apb answer, zero wait states
    n.rdy = psel_i & ~penable_i;
    n.err = 1'b0;
    if (psel_i && !penable_i) begin
      n.rdata = 32'h0;
      unique case (paddr_i)
        fca_pkg::A_CTRL:  n.rdata = {22'h0, q.ctrl};
        fca_pkg::A_POL:   n.rdata = {22'h0, q.pol};
        fca_pkg::A_LEN:   n.rdata = {26'h0, q.len};
        fca_pkg::A_LRST:  n.rdata = 32'h0;
        fca_pkg::A_SDLY:  n.rdata = {16'h0, q.sdly};
        fca_pkg::A_RECL:  n.rdata = {16'h0, q.recl};
        8'h18, 8'h1c, 8'h20, 8'h24, 8'h28:
          n.rdata = {16'h0, q.dead[3'(paddr_i[7:2] - fca_pkg::A_DEAD0[7:2])]};
        fca_pkg::A_PULSE: n.rdata = {16'h0, q.pulse};
        fca_pkg::A_CMD:   n.rdata = 32'h0;
        fca_pkg::A_ILKM:  n.rdata = {22'h0, q.ilkm};
        fca_pkg::A_ILKV:  n.rdata = {22'h0, q.ilkv};
        fca_pkg::A_DOC:   n.rdata = {14'h0, q.doc};
        fca_pkg::A_INACT: n.rdata = {16'h0, q.inact};
        fca_pkg::A_LEDM:  n.rdata = {4'h0, q.ledm};
        fca_pkg::A_STAT:  n.rdata = {6'h0, q.bled, 9'h0, q.fin, q.st, q.shot};
        fca_pkg::A_OBJ:   n.rdata = {7'h0, q.lastc, 1'b0, ~(obj_opn ^ obj_cls), 1'b0, obj_opn, 1'b0, obj_cls};
        default:          n.err = 1'b1;
      endcase
    end
    // register writes
    if (wr) begin
      unique case (paddr_i)
        fca_pkg::A_CTRL:  n.ctrl  = pwdata_i[9:0];
        fca_pkg::A_POL:   n.pol   = pwdata_i[9:0];
        fca_pkg::A_LEN:   n.len   = pwdata_i[5:0];
        fca_pkg::A_SDLY:  n.sdly  = pwdata_i[15:0];
        fca_pkg::A_RECL:  n.recl  = pwdata_i[15:0];
        8'h18, 8'h1c, 8'h20, 8'h24, 8'h28:
          n.dead[3'(paddr_i[7:2] - fca_pkg::A_DEAD0[7:2])] = pwdata_i[15:0];
        fca_pkg::A_PULSE: n.pulse = pwdata_i[15:0];
        fca_pkg::A_ILKM:  n.ilkm  = pwdata_i[9:0];
        fca_pkg::A_ILKV:  n.ilkv  = pwdata_i[9:0];
        fca_pkg::A_DOC:   n.doc   = pwdata_i[17:0];
        fca_pkg::A_INACT: n.inact = pwdata_i[15:0];
        fca_pkg::A_LEDM:  n.ledm  = pwdata_i[27:0];
        default:          n.ctrl  = q.ctrl;
      endcase
    end

    // latching indications, set wins over clear
    for (int i = 0; i < fca_pkg::N_LAT; i++) begin
      if (!bin_act[i]) begin
        n.lcnt[i] = 4'h0;
      end else if (tick && q.lcnt[i] <= fca_pkg::LATCH_MS) begin
        n.lcnt[i] = q.lcnt[i] + 4'h1;
      end
      n.lat[i] = (q.len[i] & (q.lcnt[i] > fca_pkg::LATCH_MS)) | (q.lat[i] & ~lat_clr);
    end

    // command select: remote, then local buttons, then channel activation
    cmd_v   = 1'b0;
    cmd_opn = 1'b0;
    cmd_obj = 3'h0;
    if (wr && paddr_i == fca_pkg::A_CMD && (pwdata_i[0] ^ pwdata_i[1])) begin
      cmd_v   = 1'b1;
      cmd_opn = pwdata_i[0];
      cmd_obj = pwdata_i[6:4];
    end else if (q.pin[fca_pkg::P_LOPN] & ~q.lprev[0]) begin
      cmd_v   = 1'b1;
      cmd_opn = 1'b1;
      cmd_obj = q.pin[fca_pkg::P_LOBJ +: 3];
    end else if (q.pin[fca_pkg::P_LCLS] & ~q.lprev[1]) begin
      cmd_v   = 1'b1;
      cmd_obj = q.pin[fca_pkg::P_LOBJ +: 3];
    end else if (fca_sel_ch(bin_act, q.inact[3:0]) & ~fca_sel_ch(q.bprev, q.inact[3:0])) begin
      cmd_v   = 1'b1;
      cmd_opn = ~q.inact[fca_pkg::IA_DIR];
      cmd_obj = q.inact[fca_pkg::IA_OBJ +: 3];
    end
    // discarded unless permitted, normal mode and a controllable object
    if (cmd_v && permit && !q.ctrl[fca_pkg::C_DOC] && cmd_obj < 3'(fca_pkg::N_CTL)) begin
      ok_m[cmd_obj] = 1'b1;
    end

    // reclose sequencer
    if (tick && q.art != 16'h0) begin
      n.art = q.art - 16'h1;
    end
    unique case (q.st)
      fca_pkg::FCA_IDLE: begin
        n.shot = 3'h0;
        if (q.ctrl[fca_pkg::C_ARE] && start_rise) begin
          if (use_dly) begin
            n.st  = fca_pkg::FCA_SDLY;
            n.art = q.sdly;
          end else begin
            n.st  = fca_pkg::FCA_DEAD;
            n.art = q.dead[0];
            ar_open[1:0] = brk_open;
          end
        end
      end
      fca_pkg::FCA_SDLY: begin
        if (!any_start) begin
          n.st = fca_pkg::FCA_IDLE;
        end else if (q.art == 16'h0) begin
          n.st  = fca_pkg::FCA_DEAD;
          n.art = q.dead[0];
          ar_open[1:0] = brk_open;
        end
      end
      fca_pkg::FCA_DEAD: begin
        if (q.art == 16'h0) begin
          n.st  = fca_pkg::FCA_RECL;
          n.art = q.recl;
          ar_close[1:0] = brk_close;
        end
      end
      fca_pkg::FCA_RECL: begin
        if (start_rise) begin
          ar_open[1:0] = brk_open;
          if (q.shot + 3'h1 >= shots_eff) begin
            n.st  = fca_pkg::FCA_FINAL;
            n.fin = 1'b1;
          end else begin
            n.st   = fca_pkg::FCA_DEAD;
            n.shot = q.shot + 3'h1;
            n.art  = q.dead[q.shot + 3'h1];
          end
        end else if (q.art == 16'h0) begin
          n.st   = fca_pkg::FCA_IDLE;
          n.shot = 3'h0;
        end
      end
      fca_pkg::FCA_FINAL: begin
        if (!any_start) begin
          n.st   = fca_pkg::FCA_IDLE;
          n.shot = 3'h0;
        end
      end
      default: n.st = fca_pkg::FCA_IDLE;
    endcase
    if (!q.ctrl[fca_pkg::C_ARE] && q.st != fca_pkg::FCA_IDLE) begin
      n.st = fca_pkg::FCA_IDLE;
    end
    if (start_rise && q.st == fca_pkg::FCA_IDLE) begin
      n.fin = 1'b0;
    end
    n.act = (n.st != fca_pkg::FCA_IDLE);                            // busy flag as a flop
    // control pulses; trip and reclose bypass the interlock
    new_open  = (cmd_opn ? ok_m : 6'h0) | ar_open | (trip_rise ? {4'h0, brk_open} : 6'h0);
    new_close = (cmd_opn ? 6'h0 : ok_m) | ar_close;
    if (new_open != 6'h0 || new_close != 6'h0) begin
      n.p_open  = q.p_open | new_open;
      n.p_close = (q.p_close | new_close) & ~(q.p_open | new_open);
      n.ptmr    = (q.pulse == 16'h0) ? 16'h1 : q.pulse;
    end else if (tick) begin
      if (q.ptmr <= 16'h1) begin
        n.ptmr    = 16'h0;
        n.p_open  = 6'h0;
        n.p_close = 6'h0;
      end else begin
        n.ptmr = q.ptmr - 16'h1;
      end
    end

    // output flops: normal commands or direct output logic
    if (q.ctrl[fca_pkg::C_DOC]) begin
      n.o_open  = (q.doc[5:0] & bin_act[5:0]) | q.p_open;
      n.o_close = q.doc[13:8] & bin_act[9:4];
      n.o_sig   = q.doc[17:16] & {fca_sel_ch(bin_act, q.inact[fca_pkg::IA_S1 +: 4]),
                                  fca_sel_ch(bin_act, q.inact[fca_pkg::IA_S0 +: 4])};
    end else begin
      n.o_open  = q.p_open;
      n.o_close = q.p_close;
      n.o_sig   = {fca_sel_ch(bin_act, q.inact[fca_pkg::IA_S1 +: 4]),
                   fca_sel_ch(bin_act, q.inact[fca_pkg::IA_S0 +: 4])};
    end
    // indicator matrix from mapped closed objects
    n.led = 16'h0;
    for (int i = 0; i < fca_pkg::N_OBJ; i++) begin
      if (obj_cls[i] && !obj_opn[i]) begin
        n.led[q.ledm[4*i +: 4]] = 1'b1;
      end
    end
    n.bled = bin_act | {4'h0, q.lat};
  end

  // state register
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      q       <= '0;
      q.ctrl  <= fca_pkg::CTRL_RST;
      q.recl  <= fca_pkg::RECL_RST;
      q.dead  <= {5{fca_pkg::DEAD_RST}};
      q.pulse <= fca_pkg::PULSE_RST;
      q.inact <= fca_pkg::INACT_RST;
      q.ledm  <= fca_pkg::LEDM_RST;
      q.st    <= fca_pkg::FCA_IDLE;
    end else begin
      q <= n;
    end
  end

  assign prdata_o           = q.rdata;
  assign pready_o           = q.rdy;
  assign pslverr_o          = q.err;
  assign object_open_out_o  = q.o_open;
  assign object_close_out_o = q.o_close;
  assign signal_out_o       = q.o_sig;
  assign led_o              = q.led;
  assign bin_led_o          = q.bled;
  assign final_trip_o       = q.fin;
  assign ar_active_o        = q.act;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  sequence s_dead_done;
    q.st == fca_pkg::FCA_DEAD && q.art == 16'h0 && q.ctrl[fca_pkg::C_ARE] && !trip_rise;
  endsequence
  sequence s_reclose_out;
    q.p_close[0] | q.p_close[1] ##1 (object_close_out_o[0] | object_close_out_o[1]) || q.ctrl[fca_pkg::C_DOC];
  endsequence

  AST_SHOT_MAX: assert property (q.shot < 3'(fca_pkg::N_SHOT)) else $error("shot index beyond five");
  AST_DEAD_CLOSE: assert property (s_dead_done |=> q.st == fca_pkg::FCA_RECL && q.art == $past(q.recl) ##0 s_reclose_out)
    else $error("dead time end without reclose");
  AST_RECLAIM_RST: assert property (q.st == fca_pkg::FCA_RECL && q.art == 16'h0 && !start_rise && q.ctrl[fca_pkg::C_ARE]
    |=> q.st == fca_pkg::FCA_IDLE ##1 q.shot == 3'h0) else $error("reclaim expiry did not reset");
  AST_FINAL: assert property (q.st == fca_pkg::FCA_RECL && start_rise && q.ctrl[fca_pkg::C_ARE] && q.shot + 3'h1 >= shots_eff
    |=> final_trip_o && q.st == fca_pkg::FCA_FINAL) else $error("missed final trip");
  AST_DUPLEX: assert property ((q.ctrl[fca_pkg::C_DUP] and s_dead_done) |=> q.p_close[1:0] != 2'h3)
    else $error("duplex reclosed both breakers");
  AST_TRIP_BYPASS: assert property (trip_rise |=> q.p_open[0] ##1 object_open_out_o[0])
    else $error("trip blocked");
  AST_ILK_BLOCK: assert property (cmd_v && !permit && !trip_rise && q.st == fca_pkg::FCA_IDLE && !start_rise
    |=> q.p_open == $past(q.p_open) || q.p_open == 6'h0) else $error("refused command acted");
  AST_LATCH_CLR: assert property (lat_clr && q.lcnt == '0 |=> q.lat == 6'h0) else $error("latch not cleared");
  AST_LATCH_SET: assert property (q.len[0] && q.lcnt[0] > fca_pkg::LATCH_MS |=> q.lat[0] ##1 bin_led_o[0])
    else $error("latch not set");
  AST_DOC: assert property (q.ctrl[fca_pkg::C_DOC] && $stable(q.ctrl) |=> object_close_out_o == ($past(q.doc[13:8]) &
    $past(bin_act[9:4]))) else $error("direct output mismatch");
  AST_NORMAL: assert property (!q.ctrl[fca_pkg::C_DOC] |=> object_close_out_o == $past(q.p_close))
    else $error("normal output not from command");
  AST_APB_RDY: assert property (psel_i && !penable_i |=> pready_o) else $error("no apb answer");

endmodule

//--- design/fca_pkg.sv
// constants for the feeder control and auto-reclose block
// Operation
// - up to five reclose shots before final trip
// - three separate start inputs can start each shot
// - optional start delay when a start input carries start signals
// - own programmable dead time per shot before reclose command
// - programmable reclaim time after each reclose command
// - duplex opens both breakers, recloses only the last one closed
// - each object read through an open input and a closed input
// - 4x4 indicator matrix, seven mapped object positions
// - six objects controllable by open and close outputs
// - seven external and three internal binary inputs
// - active level of each binary channel selectable
// - channels 0-5 may latch indication after more than 10 ms active
// - latches cleared by both buttons or writing 0 or 1
// - channel activation pulses configured output; signal outputs follow inputs
// - every command checked against interlock, else discarded
// - interlock source is object status or binary channels
// - trips bypass the interlock entirely
// - normal mode object outputs driven only by command, trip and reclose pulses
// - direct output control drives outputs from input logic
package fca_pkg;
  // pin vector layout after synchronising
  localparam int P_STA   = 0;
  localparam int P_OPN   = 3;
  localparam int P_CLS   = 10;
  localparam int P_EXT   = 17;
  localparam int P_INT   = 24;
  localparam int P_TRP   = 27;
  localparam int P_STEP  = 28;
  localparam int P_SEL   = 29;
  localparam int P_LOPN  = 30;
  localparam int P_LCLS  = 31;
  localparam int P_LOBJ  = 32;
  localparam int PIN_W   = 35;
  // sizes
  localparam int N_OBJ   = 7;
  localparam int N_CTL   = 6;
  localparam int N_BIN   = 10;
  localparam int N_LAT   = 6;
  localparam int N_SHOT  = 5;
  // timing
  localparam int CLK_HZ  = 10_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [3:0] LATCH_MS = 4'ha;
  // register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_POL   = 8'h04;
  localparam logic [7:0] A_LEN   = 8'h08;
  localparam logic [7:0] A_LRST  = 8'h0c;
  localparam logic [7:0] A_SDLY  = 8'h10;
  localparam logic [7:0] A_RECL  = 8'h14;
  localparam logic [7:0] A_DEAD0 = 8'h18;
  localparam logic [7:0] A_PULSE = 8'h2c;
  localparam logic [7:0] A_CMD   = 8'h30;
  localparam logic [7:0] A_ILKM  = 8'h34;
  localparam logic [7:0] A_ILKV  = 8'h38;
  localparam logic [7:0] A_DOC   = 8'h3c;
  localparam logic [7:0] A_INACT = 8'h40;
  localparam logic [7:0] A_LEDM  = 8'h44;
  localparam logic [7:0] A_STAT  = 8'h48;
  localparam logic [7:0] A_OBJ   = 8'h4c;
  // control and channel activation field positions
  localparam int C_DUP   = 0;
  localparam int C_DOC   = 1;
  localparam int C_ILK   = 2;
  localparam int C_ARE   = 3;
  localparam int C_SHOT  = 4;
  localparam int C_SDLY  = 7;
  localparam int IA_OBJ  = 5;
  localparam int IA_DIR  = 4;
  localparam int IA_S0   = 8;
  localparam int IA_S1   = 12;
  // reset values
  localparam logic [9:0]  CTRL_RST  = 10'h058;
  localparam logic [15:0] PULSE_RST = 16'h0064;
  localparam logic [15:0] RECL_RST  = 16'h03e8;
  localparam logic [15:0] DEAD_RST  = 16'h01f4;
  localparam logic [15:0] INACT_RST = 16'hff0f;
  localparam logic [27:0] LEDM_RST  = 28'h6543210;
  // reclose sequencer states, gray along the usual path
  typedef enum logic [2:0] {
    FCA_IDLE  = 3'h0,
    FCA_SDLY  = 3'h1,
    FCA_DEAD  = 3'h3,
    FCA_RECL  = 3'h2,
    FCA_FINAL = 3'h6
  } fca_ar_e;
endpackage

//--- dv/fca_brk.sv
// breaker and contact model answering the open and close pulses
`timescale 1ns/1ps
module fca_brk (
  input  wire logic       clk_i,
  input  wire logic [5:0] open_cmd_i,
  input  wire logic [5:0] close_cmd_i,
  output logic      [6:0] open_o,
  output logic      [6:0] closed_o
);
  // all objects start closed
  initial begin
    open_o = 7'h00;
    closed_o = 7'h7f;
  end
  // contacts follow the pulses, open wins over close
  always @(posedge clk_i) begin
    for (int i = 0; i < 6; i++) begin
      if (open_cmd_i[i]) begin
        open_o[i] <= 1'b1;
        closed_o[i] <= 1'b0;
      end else if (close_cmd_i[i]) begin
        open_o[i] <= 1'b0;
        closed_o[i] <= 1'b1;
      end
    end
  end
endmodule

//--- dv/tb.sv
// self-checking bench for the feeder control block
`timescale 1ns/1ps
module tb;
  logic        mclk_i = 0, rst_b_i = 0, psel = 0, pen = 0, pwr = 0, trip = 0, lop = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, ftrip, aract;
  logic [2:0]  st = 3'h0, lobj = 3'h0;
  logic [1:0]  btn = 2'h0, sig;
  logic [6:0]  oo, oc, ext = 7'h00;
  logic [5:0]  oout, cout;
  logic [9:0]  bled;
  logic [15:0] led;
  logic [11:0] pv = 12'h0;
  logic [32:0] rq[$];
  logic [11:0] pq[$];
  logic [7:0]  ra[7] = '{fca_pkg::A_CTRL, fca_pkg::A_PULSE, fca_pkg::A_RECL, fca_pkg::A_DEAD0,
                         fca_pkg::A_INACT, fca_pkg::A_LEDM, 8'h50};
  logic [32:0] rv[7] = '{33'h58, 33'h64, 33'h3e8, 33'h1f4, 33'hff0f, 33'h6543210, 33'h100000000};
  int          fails = 0, samples_checked = 0, cyc = 0, obj;
  fca_top #(.TICK_CYC(20)) i_fca_top (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .reclose_start_a_i(st[0]), .reclose_start_b_i(st[1]), .reclose_start_c_i(st[2]),
    .trip_i(trip), .obj_open_i(oo), .obj_closed_i(oc), .ext_in_i(ext), .int_in_i(st),
    .btn_step_i(btn[0]), .btn_select_i(btn[1]), .loc_open_i(lop), .loc_close_i(1'b0), .loc_obj_i(lobj),
    .object_open_out_o(oout), .object_close_out_o(cout), .signal_out_o(sig), .led_o(led),
    .bin_led_o(bled), .final_trip_o(ftrip), .ar_active_o(aract));
  fca_brk i_fca_brk (.clk_i(mclk_i), .open_cmd_i(oout), .close_cmd_i(cout), .open_o(oo), .closed_o(oc));
  always #50 mclk_i = ~mclk_i;
  task automatic chk(input string what, input logic [32:0] e, input logic [32:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic report_and_stop();
    if (pq.size() + rq.size() != 0) fails++;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watcher: read data and rising pulses against the oldest notes
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
    if (psel && pen && pready === 1'b1 && !pwr) chk("read", rq.pop_front(), {pslverr, prdata});
    if ({cout, oout} !== 12'h0 && pv === 12'h0) chk("pulse", {21'h0, pq.pop_front()}, {21'h0, cout, oout});
    pv <= {cout, oout};
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i) pen <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  initial begin
    void'($urandom(68));
    wt(3);
    rst_b_i <= 1'b1;
    wt(3);
    foreach (ra[i]) rd(ra[i], rv[i]);
    $display("test reset values done");
    wr(fca_pkg::A_PULSE, 32'h2);
    wr(fca_pkg::A_DEAD0, 32'h3);
    wr(fca_pkg::A_RECL, 32'h5);
    obj = $urandom % 6;
    wr(fca_pkg::A_ILKM, 32'h40);
    wr(fca_pkg::A_ILKV, 32'h0);
    wr(fca_pkg::A_CMD, 32'(obj * 16 + 1));
    wt(80);
    wr(fca_pkg::A_ILKV, 32'h40);
    pq.push_back(12'(1 << obj));
    lobj <= 3'(obj);
    wt(1);
    lop <= 1'b1;
    wt(10);
    lop <= 1'b0;
    wt(80);
    pq.push_back(12'(64 << obj));
    wr(fca_pkg::A_CMD, 32'(obj * 16 + 2));
    wt(80);
    wr(fca_pkg::A_ILKV, 32'h0);
    pq.push_back(12'h1);
    trip <= 1'b1;
    wt(10);
    trip <= 1'b0;
    wt(80);
    $display("test commands done");
    wr(fca_pkg::A_ILKM, 32'h0);
    wr(fca_pkg::A_CTRL, 32'h18);
    pq.push_back(12'h1);
    pq.push_back(12'h40);
    st[0] <= 1'b1;
    wt(10);
    st[0] <= 1'b0;
    while (pq.size() != 0) wt(1);
    wt(300);
    rd(fca_pkg::A_STAT, 33'h0);
    $display("test reclose done");
    wr(fca_pkg::A_LEN, 32'h1);
    wr(fca_pkg::A_INACT, 32'hf00f);
    for (int k = 0; k < 2; k++) begin
      ext <= 7'h01;
      wt(300);
      chk("signal", 33'h1, {31'h0, sig});
      chk("bin_led", 33'h1, {23'h0, bled});
      ext <= 7'h00;
      wt(20);
      rd(fca_pkg::A_STAT, 33'h10000);
      if (k == 0) begin
        btn <= 2'h3;
        wt(10);
        btn <= 2'h0;
        wt(10);
      end else
        wr(fca_pkg::A_LRST, 32'h1);
      rd(fca_pkg::A_STAT, 33'h0);
    end
    $display("test latch done");
    wr(fca_pkg::A_CTRL, 32'h19);
    pq.push_back(12'h3);
    pq.push_back(12'h40);
    st[0] <= 1'b1;
    wt(10);
    st[0] <= 1'b0;
    while (pq.size() != 0) wt(1);
    chk("active", 33'h1, {32'h0, aract});
    wt(50);
    pq.push_back(12'h3);
    st[0] <= 1'b1;
    while (pq.size() != 0) wt(1);
    wt(2);
    chk("final", 33'h1, {32'h0, ftrip});
    st[0] <= 1'b0;
    wt(10);
    chk("active", 33'h0, {32'h0, aract});
    chk("led", 33'h7c, {17'h0, led});
    $display("test final trip done");
    pq.push_back(12'h40);
    wr(fca_pkg::A_DOC, 32'h100);
    wr(fca_pkg::A_CTRL, 32'h1a);
    ext <= 7'h10;
    wt(20);
    ext <= 7'h00;
    wt(20);
    wr(fca_pkg::A_CTRL, 32'h18);
    $display("test direct output done");
    report_and_stop();
  end
endmodule
